// *** dpm_pkg.sv ***
// dpm_pkg.sv: constants and types shared by the drive protection monitor
`default_nettype none
package dpm_pkg;
  // clock and supervision time base
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned TICK_MS  = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_S = 1000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DUTY  = 8'h04;
  localparam logic [7:0] OFS_DEVL  = 8'h08;
  localparam logic [7:0] OFS_DEVT  = 8'h0c;
  localparam logic [7:0] OFS_OSL   = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_FCLR  = 8'h18;
  // control register field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_LINK_LSB = 4;
  localparam int unsigned CTRL_MODE_LSB = 8;
  // field widths
  localparam int unsigned SPD_W  = 16;
  localparam int unsigned LVL_W  = 14;
  localparam int unsigned DEVT_W = 7;
  localparam int unsigned OSL_W  = 12;
  localparam int unsigned DUTY_W = 5;
  localparam int unsigned MS_W   = 17;
  // selection values of brake_converter_select and link_start_select
  localparam logic [2:0] SEL_DUTY    = 3'h1;
  localparam logic [2:0] SEL_HC      = 3'h3;
  localparam logic [2:0] SEL_HC_LINK = 3'h4;
  localparam logic [1:0] LINK_AUTO   = 2'h2;
  // ranges and reset values
  localparam logic [DUTY_W-1:0] DUTY_MAX = 5'h1e;   // 30 %
  localparam logic [DUTY_W-1:0] DUTY_RST = 5'h00;
  localparam logic [LVL_W-1:0]  DEVL_MAX = 14'h05dc; // 1500 r/min
  localparam logic [LVL_W-1:0]  DEVL_OFF = 14'h270f; // 9999 disables
  localparam logic [LVL_W-1:0]  DEVL_RST = 14'h270f;
  localparam logic [DEVT_W-1:0] DEVT_MAX = 7'h64;    // 100 s
  localparam logic [DEVT_W-1:0] DEVT_RST = 7'h0c;    // 12 s
  localparam logic [OSL_W-1:0]  OSL_MAX  = 12'he10;  // 3600 r/min
  localparam logic [OSL_W-1:0]  OSL_RST  = 12'hbb8;  // 3000 r/min
  localparam logic [23:0]       OS_PCT   = 24'h000073; // 115 %
  localparam logic [23:0]       PCT_ONE  = 24'h000064; // 100 %
  // control modes
  typedef enum logic [1:0] {
    MODE_SPEED  = 2'b00,
    MODE_TORQUE = 2'b01,
    MODE_VF     = 2'b10
  } dpm_mode_t;
  // latched fault, shown on the fault code output
  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_DEV  = 2'b01,
    FLT_OS   = 2'b10,
    FLT_OPT  = 2'b11
  } dpm_fault_t;
endpackage
`default_nettype wire

// *** dpm_chk_if.sv ***
// dpm_chk_if.sv: speed supervision signals between control and checker
`default_nettype none
interface dpm_chk_if;
  logic signed [dpm_pkg::SPD_W-1:0]  cmd;
  logic signed [dpm_pkg::SPD_W-1:0]  act;
  logic        [dpm_pkg::LVL_W-1:0]  dev_level;
  logic        [dpm_pkg::DEVT_W-1:0] dev_time;
  logic        [dpm_pkg::OSL_W-1:0]  os_level;
  logic                              dev_en;
  logic                              os_en;
  logic                              tick;
  logic                              dev_hit;
  logic                              os_hit;
  modport ctl (output cmd, act, dev_level, dev_time, os_level, dev_en, os_en, tick,
               input dev_hit, os_hit);
  modport mon (input cmd, act, dev_level, dev_time, os_level, dev_en, os_en, tick,
               output dev_hit, os_hit);
endinterface
`default_nettype wire

// *** dpm_tick.sv ***
// dpm_tick.sv: millisecond tick for the deviation timer
`default_nettype none
module dpm_tick #(
  parameter int unsigned TICK_CYC = dpm_pkg::TICK_CYC
) (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_n_i,   // synchronised reset, active low
  input  wire logic ce_i,      // clock enable
  output logic      tick_o     // one-cycle tick
);
  logic [31:0] cnt_q;

  // free running divider, frozen with the clock enable
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
    end else if (ce_i) begin
      cnt_q <= (cnt_q >= 32'(TICK_CYC - 1)) ? 32'h0 : cnt_q + 32'h1;
    end
  end

  // tick sits on the wrap so it spans exactly one enabled cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= (cnt_q >= 32'(TICK_CYC - 1));
    end
  end
endmodule // dpm_tick
`default_nettype wire

// *** dpm_speed_chk.sv ***
// dpm_speed_chk.sv: speed deviation timer and overspeed comparator
`default_nettype none
module dpm_speed_chk (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_n_i,   // synchronised reset, active low
  input  wire logic ce_i,      // clock enable
  dpm_chk_if.mon    chk        // supervision bundle
);
  logic [16:0]               diff_w;
  logic [16:0]               diff_mag;
  logic [16:0]               act_w;
  logic [dpm_pkg::SPD_W-1:0] act_mag;
  logic [dpm_pkg::MS_W-1:0]  limit_ms;
  logic [dpm_pkg::MS_W-1:0]  ms_q;
  logic                      exceed;
  logic                      os_now;

  // magnitudes; 17 bits so that the most negative speed still fits
  always_comb begin
    diff_w   = {chk.cmd[15], chk.cmd} - {chk.act[15], chk.act};
    diff_mag = diff_w[16] ? 17'(-diff_w) : diff_w;
    act_w    = {chk.act[15], chk.act};
    act_mag  = act_w[16] ? 16'(-act_w) : 16'(act_w);
    exceed   = chk.dev_en && (diff_mag > 17'(chk.dev_level));
    limit_ms = dpm_pkg::MS_W'(chk.dev_time) * dpm_pkg::MS_W'(dpm_pkg::MS_PER_S);
    os_now   = chk.os_en && (24'(act_mag) * dpm_pkg::PCT_ONE >=
                             24'(chk.os_level) * dpm_pkg::OS_PCT);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_q <= '0;
    end else if (ce_i) begin
      if (!exceed) begin
        ms_q <= '0;
      end else if (chk.tick && ms_q != '1) begin
        ms_q <= ms_q + 1'b1;
      end
    end
  end

  // hit only while checking is enabled
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk.dev_hit <= 1'b0;
      chk.os_hit  <= 1'b0;
    end else if (ce_i) begin
      chk.dev_hit <= exceed && (ms_q > limit_ms);
      chk.os_hit  <= os_now;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_dev_off;
    ce_i && !chk.dev_en |=> !chk.dev_hit;
  endproperty
  a_dev_off: assert property (p_dev_off) else $error("deviation hit while disabled");

  property p_os_hit;
    ce_i && chk.os_en && (24'(act_mag) * dpm_pkg::PCT_ONE >=
                          24'(chk.os_level) * dpm_pkg::OS_PCT) |=> chk.os_hit;
  endproperty
  a_os_hit: assert property (p_os_hit) else $error("overspeed not flagged");
endmodule // dpm_speed_chk
`default_nettype wire

// *** dpm_top.sv ***
// dpm_top.sv: drive protection monitor with apb registers
//
// Function
// - the braking duty is written only while the selection is 1.
// - small models take a duty of 0 to 30 percent, large models hold it at 0.
// - with the selection at 0 the duty reads as zero and refuses writes.
// - in modes 3 and 4 input two shuts off output and undervoltage, brake and loss checks stop.
// - in mode 4 with link start 2 input three takes the converter power failure signal.
// - in modes 3 and 4 voltage on the own mains terminals raises an option error.
// - the converter ready level allows running and its drop stops output within 3 ms.
// - a converter power failure only stores the run command for automatic restart.
// - a speed error above the level for longer than the time latches a deviation fault.
// - the deviation level takes 0 to 1500 or 9999, which disables the check; reset 9999.
// - the deviation time takes 0 to 100 s, reset 12 s, and reads as zero while the level is 9999.
// - torque control suppresses deviation detection.
// - actual speed at 115 percent of the overspeed level latches an overspeed fault and alarm.
// - the overspeed level takes 0 to 3600 r/min with reset 3000.
// - V/F control skips overspeed detection.
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
module dpm_top #(
  parameter bit          LARGE_MODEL = 1'b0,              // model class
  parameter int unsigned TICK_CYC    = dpm_pkg::TICK_CYC // cycles per ms
) (
  input  wire logic                     clk_sys_i,              // 100 MHz clock
  input  wire logic                     rst_n_i,                // async reset, active low
  input  wire logic                     ce_i,                   // clock enable
  input  wire logic [7:0]               paddr_i,                // apb address
  input  wire logic                     psel_i,                 // apb select
  input  wire logic                     penable_i,              // apb enable
  input  wire logic                     pwrite_i,               // apb direction
  input  wire logic [31:0]              pwdata_i,               // apb write data
  output logic      [31:0]              prdata_o,               // apb read data
  output logic                          pready_o,               // apb ready
  output logic                          pslverr_o,              // apb error
  input  wire logic signed [15:0]       speed_cmd_i,            // commanded speed r/min
  input  wire logic signed [15:0]       speed_act_i,            // measured speed r/min
  input  wire logic                     run_cmd_i,              // run command
  input  wire logic                     digital_input_two_i,    // converter ready pin
  input  wire logic                     digital_input_three_i,  // converter failure pin
  input  wire logic                     mains_present_i,        // own mains voltage pin
  output logic                          run_enable_o,           // output stage enable
  output logic                          alarm_o,                // alarm contact
  output logic      [1:0]               fault_code_o,           // latched fault code
  output logic                          undervoltage_detect_o,  // undervoltage check on
  output logic                          brake_res_en_o,         // brake resistor on
  output logic                          pf_detect_en_o,         // own loss check on
  output logic                          restart_cmd_o,          // stored run command
  output logic      [4:0]               brake_duty_ratio_o      // duty in percent
);
  logic [1:0]                rst_sync_q;
  logic                      rst_q;
  logic [2:0]                pin_s1_q;
  logic [2:0]                pin_s2_q;
  logic                      din3_prev_q;
  logic [2:0]                brake_converter_select_q;
  logic [1:0]                link_start_select_q;
  dpm_pkg::dpm_mode_t        mode_q;
  logic [4:0]                regen_brake_duty_q;
  logic [13:0]               speed_deviation_level_q;
  logic [6:0]                speed_deviation_time_q;
  logic [11:0]               overspeed_level_q;
  dpm_pkg::dpm_fault_t       fault_q;
  dpm_pkg::dpm_fault_t       fault_d;
  logic                      restart_q;
  logic                      run_en_q;
  logic [31:0]               rd_d;
  logic                      err_d;
  logic                      wr_ok;
  logic                      wr_acc;
  logic                      clr_acc;
  logic                      hc_mode;
  logic                      pf_accept;
  logic                      shutoff;
  logic                      din2_s;
  logic                      din3_s;
  logic                      mains_s;
  logic [31:0]               wd;
  dpm_chk_if                 chk ();

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // pin synchronisers, first stage feeds only the second
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge rst_q) begin
      if (!rst_q) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
      end else if (ce_i) begin
        pin_s1_q[i] <= (i == 0) ? digital_input_two_i :
                       (i == 1) ? digital_input_three_i : mains_present_i;
        pin_s2_q[i] <= pin_s1_q[i];
      end
    end
  end
  assign din2_s  = pin_s2_q[0];
  assign din3_s  = pin_s2_q[1];
  assign mains_s = pin_s2_q[2];

  // converter modes
  // converter mode decode
  assign hc_mode   = (brake_converter_select_q == dpm_pkg::SEL_HC) ||
                     (brake_converter_select_q == dpm_pkg::SEL_HC_LINK);
  assign pf_accept = (brake_converter_select_q == dpm_pkg::SEL_HC_LINK) &&
                     (link_start_select_q == dpm_pkg::LINK_AUTO);
  assign shutoff   = hc_mode && !din2_s;

  // apb: zero wait states, data and error prepared in the setup cycle
  assign pready_o = 1'b1;
  assign wd       = pwdata_i;
  assign wr_acc   = ce_i && psel_i && penable_i && pwrite_i;
  assign clr_acc  = wr_acc && paddr_i == dpm_pkg::OFS_FCLR && wd[0];

  // value check of each write; refused writes leave the register alone
  always_comb begin
    wr_ok = 1'b1;
    case (paddr_i)
      dpm_pkg::OFS_CTRL: wr_ok = wd[9:8] != 2'b11;
      dpm_pkg::OFS_DUTY: wr_ok = brake_converter_select_q == dpm_pkg::SEL_DUTY &&
                                 (LARGE_MODEL ? wd[31:0] == 32'h0 :
                                  wd[31:0] <= 32'(dpm_pkg::DUTY_MAX));
      dpm_pkg::OFS_DEVL: wr_ok = wd[31:0] <= 32'(dpm_pkg::DEVL_MAX) ||
                                 wd[31:0] == 32'(dpm_pkg::DEVL_OFF);
      dpm_pkg::OFS_DEVT: wr_ok = wd[31:0] <= 32'(dpm_pkg::DEVT_MAX);
      dpm_pkg::OFS_OSL:  wr_ok = wd[31:0] <= 32'(dpm_pkg::OSL_MAX);
      dpm_pkg::OFS_FCLR: wr_ok = 1'b1;
      default:           wr_ok = 1'b0;
    endcase
  end

  // read mux; hidden registers read as zero
  always_comb begin
    rd_d  = 32'h0;
    err_d = pwrite_i ? !wr_ok : 1'b0;
    case (paddr_i)
      dpm_pkg::OFS_CTRL: rd_d = {22'h0, mode_q, 2'h0, link_start_select_q,
                                 1'b0, brake_converter_select_q};
      dpm_pkg::OFS_DUTY: begin
        rd_d  = (brake_converter_select_q == 3'h0) ? 32'h0 : 32'(regen_brake_duty_q);
        err_d = (brake_converter_select_q == 3'h0) || (pwrite_i && !wr_ok);
      end
      dpm_pkg::OFS_DEVL: rd_d = 32'(speed_deviation_level_q);
      dpm_pkg::OFS_DEVT: rd_d = (speed_deviation_level_q == dpm_pkg::DEVL_OFF) ?
                                32'h0 : 32'(speed_deviation_time_q);
      dpm_pkg::OFS_OSL:  rd_d = 32'(overspeed_level_q);
      dpm_pkg::OFS_STAT: rd_d = {24'h0, restart_q, mains_s, din3_s, din2_s,
                                 run_en_q, alarm_o, fault_q};
      dpm_pkg::OFS_FCLR: rd_d = 32'h0;
      default:           err_d = 1'b1;
    endcase
  end

  // read data and error registered at the setup edge
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i && psel_i && !penable_i) begin
      prdata_o  <= pwrite_i ? 32'h0 : rd_d;
      pslverr_o <= err_d;
    end
  end

  // settings registers, written in the access cycle
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      brake_converter_select_q <= 3'h0;
      link_start_select_q      <= 2'h0;
      mode_q                   <= dpm_pkg::MODE_SPEED;
      regen_brake_duty_q       <= dpm_pkg::DUTY_RST;
      speed_deviation_level_q  <= dpm_pkg::DEVL_RST;
      speed_deviation_time_q   <= dpm_pkg::DEVT_RST;
      overspeed_level_q        <= dpm_pkg::OSL_RST;
    end else if (wr_acc && wr_ok) begin
      case (paddr_i)
        dpm_pkg::OFS_CTRL: begin
          brake_converter_select_q <= wd[dpm_pkg::CTRL_SEL_LSB +: 3];
          link_start_select_q      <= wd[dpm_pkg::CTRL_LINK_LSB +: 2];
          mode_q <= dpm_pkg::dpm_mode_t'(wd[dpm_pkg::CTRL_MODE_LSB +: 2]);
        end
        dpm_pkg::OFS_DUTY: regen_brake_duty_q      <= wd[4:0];
        dpm_pkg::OFS_DEVL: speed_deviation_level_q <= wd[13:0];
        dpm_pkg::OFS_DEVT: speed_deviation_time_q  <= wd[6:0];
        dpm_pkg::OFS_OSL:  overspeed_level_q       <= wd[11:0];
        default: ;
      endcase
    end
  end

  // supervision bundle towards the checker
  assign chk.cmd       = speed_cmd_i;
  assign chk.act       = speed_act_i;
  assign chk.dev_level = speed_deviation_level_q;
  assign chk.dev_time  = speed_deviation_time_q;
  assign chk.os_level  = overspeed_level_q;
  assign chk.dev_en    = speed_deviation_level_q != dpm_pkg::DEVL_OFF &&
                         mode_q != dpm_pkg::MODE_TORQUE;
  assign chk.os_en     = mode_q != dpm_pkg::MODE_VF;

  dpm_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_q),
    .ce_i      (ce_i),
    .tick_o    (chk.tick)
  );

  dpm_speed_chk u_chk (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_q),
    .ce_i      (ce_i),
    .chk       (chk.mon)
  );

  // fault latch: first fault holds, a new event beats a clear
  always_comb begin
    fault_d = fault_q;
    if (fault_q == dpm_pkg::FLT_NONE || clr_acc) begin
      if (hc_mode && mains_s) begin
        fault_d = dpm_pkg::FLT_OPT;
      end else if (chk.os_hit) begin
        fault_d = dpm_pkg::FLT_OS;
      end else if (chk.dev_hit) begin
        fault_d = dpm_pkg::FLT_DEV;
      end else begin
        fault_d = dpm_pkg::FLT_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      fault_q <= dpm_pkg::FLT_NONE;
    end else if (ce_i) begin
      fault_q <= fault_d;
    end
  end

  // store run command on failure edge
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      din3_prev_q <= 1'b0;
      restart_q   <= 1'b0;
    end else if (ce_i) begin
      din3_prev_q <= din3_s;
      if (!pf_accept) begin
        restart_q <= 1'b0;
      end else if (din3_s && !din3_prev_q) begin
        restart_q <= run_cmd_i;
      end
    end
  end

  // run only with no fault and, in modes 3 and 4, with ready
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      run_en_q <= 1'b0;
    end else if (ce_i) begin
      run_en_q <= run_cmd_i && !shutoff && fault_d == dpm_pkg::FLT_NONE;
    end
  end

  assign run_enable_o = run_en_q;
  assign fault_code_o = fault_q;
  assign alarm_o      = fault_q != dpm_pkg::FLT_NONE;
  assign undervoltage_detect_o = !hc_mode;
  assign brake_res_en_o        = !hc_mode;
  assign pf_detect_en_o        = !hc_mode;
  assign restart_cmd_o         = restart_q;
  assign brake_duty_ratio_o    = regen_brake_duty_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_q);

  property p_duty_lock;
    wr_acc && paddr_i == dpm_pkg::OFS_DUTY && brake_converter_select_q != dpm_pkg::SEL_DUTY
      |=> $stable(regen_brake_duty_q);
  endproperty
  a_duty_lock: assert property (p_duty_lock) else $error("duty written while locked");
  property p_duty_range;
    regen_brake_duty_q <= dpm_pkg::DUTY_MAX && (!LARGE_MODEL || regen_brake_duty_q == 5'h0);
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty out of range");
  property p_duty_hide;
    ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == dpm_pkg::OFS_DUTY &&
      brake_converter_select_q == 3'h0 |=> prdata_o == 32'h0 && pslverr_o;
  endproperty
  a_duty_hide: assert property (p_duty_hide) else $error("hidden duty visible");
  property p_shutoff;
    ce_i && hc_mode && !digital_input_two_i ##1 ce_i [*2] |-> ##[1:2] !run_enable_o;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("output not stopped on ready drop");
  property p_opt_err;
    ce_i && hc_mode && mains_s |=> fault_q != dpm_pkg::FLT_NONE;
  endproperty
  a_opt_err: assert property (p_opt_err) else $error("option error not raised");
  property p_fault_hold;
    ce_i && fault_q != dpm_pkg::FLT_NONE && !clr_acc |=> $stable(fault_q) && !run_enable_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault not held");
  property p_devl_range;
    speed_deviation_level_q <= dpm_pkg::DEVL_MAX ||
      speed_deviation_level_q == dpm_pkg::DEVL_OFF;
  endproperty
  a_devl_range: assert property (p_devl_range) else $error("deviation level out of range");
  property p_osl_range;
    overspeed_level_q <= dpm_pkg::OSL_MAX && speed_deviation_time_q <= dpm_pkg::DEVT_MAX;
  endproperty
  a_osl_range: assert property (p_osl_range) else $error("level or time out of range");
endmodule // dpm_top
`default_nettype wire

// *** dpm_conv_model.sv ***
// converter partner model: ready level and power failure flag
`default_nettype none
module dpm_conv_model (
  input  wire logic clk_i,   // system clock
  input  wire logic trip_i,  // bench asks for a failure
  output logic      ready_o, // converter ready, high=ready
  output logic      pf_o     // power failure, high=failure
);
  timeunit 1ns;
  timeprecision 1ns;
  // a failure drops ready and raises the flag together
  always_ff @(posedge clk_i) begin
    ready_o <= !trip_i;
    pf_o    <= trip_i;
  end
endmodule // dpm_conv_model
`default_nettype wire

// *** drive_protection_monitor_test.sv ***
// self-checking bench of the drive protection monitor
`default_nettype none
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin bad_count++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module drive_protection_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic               trip = 0, mains = 0, pready, pslverr, run_en, alarm;
  logic               uv_en, brk, pfd, restart, ready, pf;
  logic        [7:0]  paddr = 8'h00;
  logic        [31:0] pwdata = 32'h0, prdata;
  logic        [1:0]  fault;
  logic        [4:0]  duty;
  logic signed [15:0] cmd = 16'sh0, act = 16'sh0;
  int                 bad_count = 0, n_tests = 0, cyc = 0;
  // short tick keeps the deviation timer quick
  dpm_top #(.LARGE_MODEL(1'b0), .TICK_CYC(10)) i_dpm_top (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_i(1'b1), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .speed_cmd_i(cmd), .speed_act_i(act),
    .run_cmd_i(1'b1), .digital_input_two_i(ready), .digital_input_three_i(pf),
    .mains_present_i(mains), .run_enable_o(run_en), .alarm_o(alarm), .fault_code_o(fault),
    .undervoltage_detect_o(uv_en), .brake_res_en_o(brk), .pf_detect_en_o(pfd),
    .restart_cmd_o(restart), .brake_duty_ratio_o(duty));
  dpm_conv_model i_dpm_conv_model (.clk_i(clk_sys), .trip_i(trip), .ready_o(ready),
    .pf_o(pf));
  // clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // one apb transfer, read data checked only on reads
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, ed,
                     input logic ee);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    if (!w) `CHK(prdata, ed)
    `CHK(pslverr, ee)
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // bounded wait for a fault code
  task automatic wflt(input logic [1:0] c);
    for (int i = 0; i < 300 && fault !== c; i++) @(posedge clk_sys);
    `CHK(fault, c)
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(0, dpm_pkg::OFS_DEVL, 32'h0, 32'h270f, 1'b0);
    acc(0, dpm_pkg::OFS_DEVT, 32'h0, 32'h0, 1'b0);
    acc(0, dpm_pkg::OFS_OSL, 32'h0, 32'hbb8, 1'b0);
    acc(0, dpm_pkg::OFS_DUTY, 32'h0, 32'h0, 1'b1);
    acc(1, dpm_pkg::OFS_DUTY, 32'h5, 32'h0, 1'b1);
    acc(1, dpm_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
    acc(1, dpm_pkg::OFS_DUTY, 32'h1f, 32'h0, 1'b1);
    acc(1, dpm_pkg::OFS_DUTY, 32'h1e, 32'h0, 1'b0);
    acc(0, dpm_pkg::OFS_DUTY, 32'h0, 32'h1e, 1'b0);
    `CHK(duty, 5'h1e)
    acc(1, dpm_pkg::OFS_DEVL, 32'h5dd, 32'h0, 1'b1);
    acc(1, dpm_pkg::OFS_DEVL, 32'ha, 32'h0, 1'b0);
    acc(0, dpm_pkg::OFS_DEVT, 32'h0, 32'hc, 1'b0);
    acc(1, dpm_pkg::OFS_DEVT, 32'h0, 32'h0, 1'b0);
    $display("register tests finished");
    // torque control hides a large speed error
    acc(1, dpm_pkg::OFS_CTRL, 32'h101, 32'h0, 1'b0);
    cmd <= 16'sh64;
    repeat (100) @(posedge clk_sys);
    `CHK(fault, 2'h0)
    acc(1, dpm_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
    wflt(2'h1);
    `CHK(run_en, 1'b0)
    cmd <= 16'sh72; act <= 16'sh72;
    repeat (50) @(posedge clk_sys);
    `CHK(alarm, 1'b1)
    acc(1, dpm_pkg::OFS_OSL, 32'h64, 32'h0, 1'b0);
    acc(1, dpm_pkg::OFS_FCLR, 32'h1, 32'h0, 1'b0);
    wflt(2'h0);
    cmd <= 16'sh73; act <= 16'sh73;
    wflt(2'h2);
    acc(1, dpm_pkg::OFS_CTRL, 32'h201, 32'h0, 1'b0);
    acc(1, dpm_pkg::OFS_FCLR, 32'h1, 32'h0, 1'b0);
    repeat (50) @(posedge clk_sys);
    `CHK(fault, 2'h0)
    $display("speed tests finished");
    // converter handshake, mode 3 then mode 4 with link start 2
    cmd <= 16'sh0; act <= 16'sh0;
    acc(1, dpm_pkg::OFS_CTRL, 32'h3, 32'h0, 1'b0);
    // mode register lands on the access edge, look one edge later
    @(posedge clk_sys);
    `CHK({uv_en, brk, pfd, run_en}, 4'h1)
    trip <= 1'b1;
    repeat (6) @(posedge clk_sys);
    `CHK(run_en, 1'b0)
    `CHK(restart, 1'b0)
    trip <= 1'b0;
    acc(1, dpm_pkg::OFS_CTRL, 32'h24, 32'h0, 1'b0);
    trip <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK({restart, fault}, 3'h4)
    mains <= 1'b1;
    wflt(2'h3);
    $display("converter tests finished");
    finish_test();
  end
endmodule // drive_protection_monitor_test
`default_nettype wire
